//--- src/tpg_core.sv
// Operation
// - a 4-bit code selects the pattern; zero means off and is reset default.
// - any active test mode replaces converter data toward the formatter.
// - some patterns go through output formatting, others bypass it.
// - patterns run without analog input; encode clock must run.
// - each of two PN reset bits reloads its generator with the seed.
// - in DDC modes I carries channel A pattern, Q carries channel B.
// - checkerboard alternates 0x1555 and 0x2aaa, starting 0x1555.
// - long PN uses x^23+x^18+1 from its seed.
// - short PN uses x^9+x^5+1 from its seed.
// - word toggle alternates all zeros and all ones, zeros first.
// - user repeat mode cycles the four user words' upper 14 bits.
// - user single mode sends four words once, then holds zero.
`timescale 1ns/100ps
`default_nettype none
module tpg_core #(
   parameter int FIFO_DEPTH_P = 16
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // register access
   input wire tpg_pkg::tpg_reg_req_t REG_REQ,
   output logic [7:0] REG_RDATA,
   // converter samples
   input wire logic [13:0] ADC_SAMPLE_A,
   input wire logic [13:0] ADC_SAMPLE_B,
   input wire logic ADC_VALID,
   output logic ADC_READY,
   // application mode
   input wire logic DDC_MODE,
   output logic [3:0] DDC_TEST_EN,
   output logic TEST_ACTIVE,
   // toward output formatting
   output tpg_pkg::tpg_sample_t OUT_SAMPLE,
   output logic OUT_VALID,
   input wire logic OUT_READY
);
   import tpg_pkg::*;

   // ************************************************************
   // register file
   // ************************************************************
   logic [7:0] tm_reg [2];
   logic [7:0] tm_next [2];
   logic [7:0] ub_reg [2][8];
   logic [7:0] ub_next [2][8];
   logic [7:0] ddc_reg [4];
   logic [7:0] ddc_next [4];
   logic [7:0] rdata_reg, rdata_next;
   logic [1:0] tm_wr;
   logic rsel;
   logic [2:0] uoff;

   assign rsel = !REG_REQ.chan[0];
   assign uoff = 3'(REG_REQ.addr - ADDR_USER_BYTE0);

   always_comb begin
      tm_next = tm_reg;
      ub_next = ub_reg;
      ddc_next = ddc_reg;
      rdata_next = rdata_reg;
      tm_wr = '0;
      if (REG_REQ.wr) begin
         // channel-specific registers land in every selected channel
         for (int c = 0; c < 2; c++) begin
            if (REG_REQ.chan[c]) begin
               if (REG_REQ.addr == ADDR_TEST_MODE) begin
                  tm_next[c] = REG_REQ.wdata;
                  tm_wr[c] = 1'b1;
               end else if (REG_REQ.addr >= ADDR_USER_BYTE0 &&
                            REG_REQ.addr <= ADDR_USER_BYTE7) begin
                  ub_next[c][uoff] = REG_REQ.wdata;
               end
            end
         end
         if (REG_REQ.addr == ADDR_DDC0_TEST) begin
            ddc_next[0] = REG_REQ.wdata;
         end else if (REG_REQ.addr == ADDR_DDC1_TEST) begin
            ddc_next[1] = REG_REQ.wdata;
         end else if (REG_REQ.addr == ADDR_DDC2_TEST) begin
            ddc_next[2] = REG_REQ.wdata;
         end else if (REG_REQ.addr == ADDR_DDC3_TEST) begin
            ddc_next[3] = REG_REQ.wdata;
         end
      end
      if (REG_REQ.rd) begin
         if (REG_REQ.addr == ADDR_TEST_MODE) begin
            rdata_next = tm_reg[rsel];
         end else if (REG_REQ.addr >= ADDR_USER_BYTE0 &&
                      REG_REQ.addr <= ADDR_USER_BYTE7) begin
            rdata_next = ub_reg[rsel][uoff];
         end else if (REG_REQ.addr == ADDR_DDC0_TEST) begin
            rdata_next = ddc_reg[0];
         end else if (REG_REQ.addr == ADDR_DDC1_TEST) begin
            rdata_next = ddc_reg[1];
         end else if (REG_REQ.addr == ADDR_DDC2_TEST) begin
            rdata_next = ddc_reg[2];
         end else if (REG_REQ.addr == ADDR_DDC3_TEST) begin
            rdata_next = ddc_reg[3];
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         tm_reg <= '{default: TM_RESET};
         ub_reg <= '{default: '{default: USER_BYTE_RESET}};
         ddc_reg <= '{default: DDC_TEST_RESET};
         rdata_reg <= 8'h00;
      end else begin
         tm_reg <= tm_next;
         ub_reg <= ub_next;
         ddc_reg <= ddc_next;
         rdata_reg <= rdata_next;
      end
   end

   assign REG_RDATA = rdata_reg;

   // the DDCs pick up the pattern only when software set both bits
   always_comb begin
      for (int d = 0; d < 4; d++) begin
         DDC_TEST_EN[d] = DDC_MODE && ddc_reg[d][DDC_TEST_I_BIT] &&
                          ddc_reg[d][DDC_TEST_Q_BIT];
      end
   end

   // ************************************************************
   // pattern generators, one per channel
   // ************************************************************
   logic [3:0] code [2];
   logic phase_reg [2];
   logic phase_next [2];
   logic [13:0] ramp_reg [2];
   logic [13:0] ramp_next [2];
   logic [1:0] uidx_reg [2];
   logic [1:0] uidx_next [2];
   logic udone_reg [2];
   logic udone_next [2];
   logic [22:0] pnl_reg [2];
   logic [22:0] pnl_next [2];
   logic [22:0] pns_reg [2];
   logic [22:0] pns_next [2];
   logic [13:0] pat [2];
   logic raw [2];
   logic [1:0] active;
   logic adv;
   tpg_sample_t fifo_in;
   logic fifo_in_valid, fifo_in_ready;

   // patterns step on the encode clock while the fifo has room, never on ADC_VALID
   assign adv = TEST_ACTIVE && fifo_in_ready;

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         code[c] = tm_reg[c][3:0];
         active[c] = (code[c] != TPG_OFF);
         phase_next[c] = phase_reg[c];
         ramp_next[c] = ramp_reg[c];
         uidx_next[c] = uidx_reg[c];
         udone_next[c] = udone_reg[c];
         pnl_next[c] = pnl_reg[c];
         pns_next[c] = pns_reg[c];
         if (tm_wr[c]) begin
            // a new code restarts its sequence from the first word
            phase_next[c] = 1'b0;
            ramp_next[c] = '0;
            uidx_next[c] = '0;
            udone_next[c] = 1'b0;
         end else if (adv) begin
            phase_next[c] = !phase_reg[c];
            ramp_next[c] = ramp_reg[c] + 14'h0001;
            if (code[c] == TPG_USER && !udone_reg[c]) begin
               uidx_next[c] = uidx_reg[c] + 2'h1;
               if (tm_reg[c][TM_USER_SINGLE_BIT] && uidx_reg[c] == 2'h3)
                  udone_next[c] = 1'b1;
            end
            if (code[c] == TPG_PN_LONG)
               pnl_next[c] = tpg_pn_next(pnl_reg[c], PN_LONG_LEN,
                                         PN_LONG_TAP);
            if (code[c] == TPG_PN_SHORT)
               pns_next[c] = tpg_pn_next(pns_reg[c], PN_SHORT_LEN,
                                         PN_SHORT_TAP);
         end
         if (tm_wr[c] || tm_reg[c][TM_PN_LONG_RST_BIT])
            pnl_next[c] = PN_LONG_SEED;
         if (tm_wr[c] || tm_reg[c][TM_PN_SHORT_RST_BIT])
            pns_next[c] = PN_SHORT_SEED;

         // fixed levels and the ramp go through formatting; the rest
         // bypass it so the receiver sees the exact documented words
         raw[c] = 1'b1;
         case (code[c])
            TPG_MID: begin
               pat[c] = PAT_ZERO;
               raw[c] = 1'b0;
            end
            TPG_POS_FS: begin
               pat[c] = PAT_POS_FS;
               raw[c] = 1'b0;
            end
            TPG_NEG_FS: begin
               pat[c] = PAT_NEG_FS;
               raw[c] = 1'b0;
            end
            TPG_CHECKER: begin
               pat[c] = phase_reg[c] ? ~PAT_CHECK_A : PAT_CHECK_A;
            end
            TPG_PN_LONG: begin
               pat[c] = tpg_pn_word(pnl_reg[c], PN_LONG_LEN, PN_LONG_TAP);
            end
            TPG_PN_SHORT: begin
               pat[c] = tpg_pn_word(pns_reg[c], PN_SHORT_LEN,
                                    PN_SHORT_TAP);
            end
            TPG_TOGGLE: begin
               pat[c] = phase_reg[c] ? PAT_ONES : PAT_ZERO;
            end
            TPG_USER: begin
               // word k is bytes 2k (low) and 2k+1 (high); top 14 bits
               pat[c] = udone_reg[c] ? PAT_ZERO :
                        {ub_reg[c][{uidx_reg[c], 1'b1}],
                         ub_reg[c][{uidx_reg[c], 1'b0}][7:2]};
            end
            TPG_RAMP: begin
               pat[c] = ramp_reg[c];
               raw[c] = 1'b0;
            end
            default: begin
               pat[c] = PAT_ZERO;
               raw[c] = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         phase_reg <= '{default: 1'b0};
         ramp_reg <= '{default: 14'h0000};
         uidx_reg <= '{default: 2'h0};
         udone_reg <= '{default: 1'b0};
         pnl_reg <= '{default: PN_LONG_SEED};
         pns_reg <= '{default: PN_SHORT_SEED};
      end else begin
         phase_reg <= phase_next;
         ramp_reg <= ramp_next;
         uidx_reg <= uidx_next;
         udone_reg <= udone_next;
         pnl_reg <= pnl_next;
         pns_reg <= pns_next;
      end
   end

   // ************************************************************
   // data path toward the formatter
   // ************************************************************
   assign TEST_ACTIVE = |active;
   // a and b become I and Q when the DDCs take the pattern
   assign fifo_in.a = active[0] ? pat[0] : ADC_SAMPLE_A;
   assign fifo_in.b = active[1] ? pat[1] : ADC_SAMPLE_B;
   assign fifo_in.test = TEST_ACTIVE;
   assign fifo_in.raw_a = active[0] && raw[0];
   assign fifo_in.raw_b = active[1] && raw[1];
   // analog samples of a channel are dropped while that channel's test runs
   assign fifo_in_valid = TEST_ACTIVE || ADC_VALID;
   assign ADC_READY = fifo_in_ready;

   tpg_fifo #(
      .WIDTH($bits(tpg_sample_t)),
      .DEPTH(FIFO_DEPTH_P)
   ) u_fifo (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(OUT_VALID),
      .out_ready(OUT_READY),
      .out_data(OUT_SAMPLE)
   );

   // ************************************************************
   // checks on channel a
   // ************************************************************
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   AST_RESET_OFF: assert property (
      @(posedge CORE_CLK) disable iff (1'b0)
      !RST_N |=> tm_reg[0] == TM_RESET && !TEST_ACTIVE)
      else $error("test mode not off after reset");
   AST_REPLACE: assert property (
      active[0] |-> fifo_in.a == pat[0] && fifo_in_valid)
      else $error("pattern did not replace converter data");
   AST_PN_RESET: assert property (
      tm_reg[0][TM_PN_LONG_RST_BIT] |=> pnl_reg[0] == PN_LONG_SEED)
      else $error("long pn not held at seed");
   AST_CHECK_FIRST: assert property (
      tm_wr[0] && REG_REQ.wdata[3:0] == TPG_CHECKER |=> pat[0] == PAT_CHECK_A)
      else $error("checkerboard did not start at 0x1555");
   AST_CHECK_ALT: assert property (
      code[0] == TPG_CHECKER && adv && !tm_wr[0] ##1 !tm_wr[0]
      |-> pat[0] == ~$past(pat[0]))
      else $error("checkerboard did not alternate");
   AST_PN_LONG_SEED: assert property (
      tm_wr[0] |=> pnl_reg[0] == PN_LONG_SEED)
      else $error("long pn not reseeded on mode write");
   AST_PN_SHORT_FIRST: assert property (
      tm_wr[0] && REG_REQ.wdata[3:0] == TPG_PN_SHORT
      |=> pat[0] == PN_SHORT_FIRST)
      else $error("short pn first word wrong");
   AST_TOGGLE: assert property (
      tm_wr[0] && REG_REQ.wdata[3:0] == TPG_TOGGLE |=> pat[0] == PAT_ZERO)
      else $error("word toggle did not start at zero");
   AST_TOGGLE_ALT: assert property (
      code[0] == TPG_TOGGLE && adv && !tm_wr[0]
      |=> pat[0] == ~$past(pat[0]))
      else $error("word toggle did not alternate");
   AST_USER_WRAP: assert property (
      code[0] == TPG_USER && !tm_reg[0][TM_USER_SINGLE_BIT] &&
      uidx_reg[0] == 2'h3 && adv && !tm_wr[0]
      |=> uidx_reg[0] == 2'h0 && !udone_reg[0])
      else $error("user repeat did not wrap");
   AST_USER_SINGLE: assert property (
      code[0] == TPG_USER && udone_reg[0] |-> pat[0] == PAT_ZERO)
      else $error("user single mode not held at zero");
   AST_RAMP: assert property (
      code[0] == TPG_RAMP && adv && !tm_wr[0]
      |=> ramp_reg[0] == $past(ramp_reg[0]) + 14'h0001)
      else $error("ramp did not step by one");

   COV_PN_LONG: cover property (code[0] == TPG_PN_LONG && adv);
   COV_USER_DONE: cover property ($rose(udone_reg[0]));
   COV_DDC_TEST: cover property (|DDC_TEST_EN && TEST_ACTIVE);
   COV_FIFO_FULL: cover property (TEST_ACTIVE && !fifo_in_ready);
endmodule // tpg_core
`default_nettype wire

//--- src/tpg_pkg.sv
`default_nettype none
package tpg_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int SMP_W = 14;
   localparam int FIFO_DEPTH = 16;
   localparam int PN_MAX = 23;
   localparam int PN_EXT = PN_MAX + SMP_W;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [11:0] ADDR_DDC0_TEST = 12'h327;
   localparam logic [11:0] ADDR_DDC1_TEST = 12'h347;
   localparam logic [11:0] ADDR_DDC2_TEST = 12'h367;
   localparam logic [11:0] ADDR_DDC3_TEST = 12'h387;
   localparam logic [11:0] ADDR_TEST_MODE = 12'h550;
   localparam logic [11:0] ADDR_USER_BYTE0 = 12'h551;
   localparam logic [11:0] ADDR_USER_BYTE7 = 12'h558;

   // ************************************************************
   // fields and reset values
   // ************************************************************
   localparam int TM_PN_LONG_RST_BIT = 4;
   localparam int TM_PN_SHORT_RST_BIT = 5;
   localparam int TM_USER_SINGLE_BIT = 7;
   localparam int DDC_TEST_I_BIT = 0;
   localparam int DDC_TEST_Q_BIT = 2;
   localparam logic [7:0] TM_RESET = 8'h00;
   localparam logic [7:0] DDC_TEST_RESET = 8'h00;
   localparam logic [7:0] USER_BYTE_RESET = 8'h00;

   // ************************************************************
   // pattern codes and words
   // ************************************************************
   typedef enum logic [3:0] {
      TPG_OFF = 4'h0, TPG_MID = 4'h1, TPG_POS_FS = 4'h2, TPG_NEG_FS = 4'h3,
      TPG_CHECKER = 4'h4, TPG_PN_LONG = 4'h5, TPG_PN_SHORT = 4'h6,
      TPG_TOGGLE = 4'h7, TPG_USER = 4'h8, TPG_RAMP = 4'hf
   } tpg_code_t;

   localparam logic [13:0] PAT_ZERO = 14'h0000;
   localparam logic [13:0] PAT_POS_FS = 14'h1fff;
   localparam logic [13:0] PAT_NEG_FS = 14'h2000;
   localparam logic [13:0] PAT_CHECK_A = 14'h1555;
   localparam logic [13:0] PAT_ONES = 14'h3fff;
   localparam int PN_LONG_LEN = 23;
   localparam int PN_LONG_TAP = 18;
   localparam int PN_SHORT_LEN = 9;
   localparam int PN_SHORT_TAP = 5;
   localparam logic [22:0] PN_LONG_SEED = 23'h003aff;
   localparam logic [22:0] PN_SHORT_SEED = 23'h000092;
   localparam logic [13:0] PN_SHORT_FIRST = 14'h125b;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] chan;
      logic [11:0] addr;
      logic [7:0] wdata;
   } tpg_reg_req_t;

   typedef struct packed {
      logic [13:0] a;
      logic [13:0] b;
      logic test;
      logic raw_a;
      logic raw_b;
   } tpg_sample_t;

   // ************************************************************
   // pn helpers: state holds the next unsent stream bits, oldest lsb
   // ************************************************************
   function automatic logic [PN_EXT-1:0] tpg_pn_stream(
      input logic [22:0] s, input int l, input int t);
      logic [PN_EXT-1:0] b;
      b = '0;
      for (int j = 0; j < PN_EXT; j++) begin
         if (j < l) begin
            b[j] = s[j];
         end else if (j < l + SMP_W) begin
            b[j] = b[j-l] ^ b[j-t];
         end
      end
      return b;
   endfunction

   function automatic logic [13:0] tpg_pn_word(input logic [22:0] s,
      input int l, input int t);
      logic [PN_EXT-1:0] b;
      logic [13:0] w;
      b = tpg_pn_stream(s, l, t);
      w = '0;
      for (int i = 0; i < SMP_W; i++) w[SMP_W-1-i] = b[i];
      return w;
   endfunction

   function automatic logic [22:0] tpg_pn_next(input logic [22:0] s,
      input int l, input int t);
      logic [PN_EXT-1:0] b;
      logic [22:0] n;
      b = tpg_pn_stream(s, l, t);
      n = '0;
      for (int i = 0; i < PN_MAX; i++) begin
         if (i < l) n[i] = b[SMP_W+i];
      end
      return n;
   endfunction

endpackage
`default_nettype wire

//--- src/tpg_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module tpg_fifo #(
   parameter int WIDTH = 31,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
   logic full, empty, push, pop;

   assign empty = (wp_reg == rp_reg);
   assign full = (wp_reg[AW-1:0] == rp_reg[AW-1:0]) &&
                 (wp_reg[AW] != rp_reg[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_reg[rp_reg[AW-1:0]];
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;

   always_comb begin
      mem_next = mem_reg;
      wp_next = wp_reg;
      rp_next = rp_reg;
      if (push) begin
         mem_next[wp_reg[AW-1:0]] = in_data;
         wp_next = wp_reg + 1'b1;
      end
      if (pop) rp_next = rp_reg + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
      end
      mem_reg <= mem_next;
   end
endmodule // tpg_fifo
`default_nettype wire

//--- verification/tpg_fmt_model.sv
`timescale 1ns/100ps
`default_nettype none
module tpg_fmt_model
   import tpg_pkg::*;
(
   // clock
   input wire logic clk,
   // stream from the generator
   input wire tpg_sample_t sample,
   input wire logic valid,
   output logic ready,
   // stall controls
   input wire logic hold,
   input wire logic slow
);
   tpg_sample_t got[$];
   logic ph = 1'b0;
   initial ready = 1'b0;
   // ********
   // drain side
   // ********
   always @(posedge clk) begin
      ph <= ~ph;
      // a slow formatter only takes every other cycle
      ready <= ~hold & (~slow | ph);
      if (valid && ready) begin
         got.push_back(sample);
      end
   end
endmodule // tpg_fmt_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import tpg_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   tpg_reg_req_t req = '0;
   logic [7:0] rdata;
   logic [13:0] adc_a = 14'h0abc;
   logic [13:0] adc_b = 14'h0123;
   logic adc_valid = 1'b1;
   logic adc_ready;
   logic ddc_mode = 1'b0;
   logic [3:0] ddc_en;
   logic test_act;
   tpg_sample_t smp;
   logic out_valid;
   logic out_ready;
   logic hold = 1'b1;
   logic slow = 1'b0;
   int fail_count = 0;
   int samples_checked = 0;
   logic [13:0] usr [4];
   // encode clock never stops while patterns are expected
   always #50 clk = ~clk;
   tpg_core #(.FIFO_DEPTH_P(16)) DUT (.CORE_CLK(clk), .RST_N(rst_n),
      .REG_REQ(req), .REG_RDATA(rdata), .ADC_SAMPLE_A(adc_a),
      .ADC_SAMPLE_B(adc_b), .ADC_VALID(adc_valid),
      .ADC_READY(adc_ready), .DDC_MODE(ddc_mode),
      .DDC_TEST_EN(ddc_en), .TEST_ACTIVE(test_act),
      .OUT_SAMPLE(smp), .OUT_VALID(out_valid), .OUT_READY(out_ready));
   tpg_fmt_model fmt (.clk(clk), .sample(smp), .valid(out_valid),
      .ready(out_ready), .hold(hold), .slow(slow));
   // ********
   // access tasks
   // ********
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [1:0] ch);
      @(posedge clk);
      req <= '{1'b1, 1'b0, ch, a, d};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rchk(input string what, input logic [11:0] a,
      input logic [1:0] ch, input logic [7:0] exp);
      @(posedge clk);
      req <= '{1'b0, 1'b1, ch, a, 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      chk(what, rdata, exp);
   endtask
   task automatic conclude();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ********
   // expected words, {raw, word}
   // ********
   function automatic logic [14:0] expw(input logic [7:0] tm,
      input int i, input logic [13:0] prev);
      logic [13:0] lpn [5] = '{14'h3fd7, 14'h0002, 14'h26e0, 14'h0a3d,
         14'h1ca6};
      logic [13:0] spn [5] = '{14'h125b, 14'h3c9a, 14'h2660, 14'h0c65,
         14'h0697};
      case (tm[3:0])
         4'h1: return {1'b0, 14'h0000};
         4'h2: return {1'b0, 14'h1fff};
         4'h3: return {1'b0, 14'h2000};
         4'h4: return {1'b1, (i % 2) ? 14'h2aaa : 14'h1555};
         4'h5: return {1'b1, tm[4] ? lpn[0] : lpn[i]};
         4'h6: return {1'b1, tm[5] ? spn[0] : spn[i]};
         4'h7: return {1'b1, (i % 2) ? 14'h3fff : 14'h0000};
         4'h8: return {1'b1, (tm[7] && i > 3) ? 14'h0 : usr[i % 4]};
         4'hf: return {1'b0, prev + 14'h0001};
         default: return '0;
      endcase
   endfunction
   // ********
   // one pattern pass: fill with converter data, switch, drain
   // ********
   task automatic run(input logic [7:0] ta, input logic [7:0] tb,
      input logic sl);
      tpg_sample_t s;
      logic [13:0] pa;
      logic [13:0] pb;
      int n;
      @(posedge clk);
      rst_n <= 1'b0;
      hold <= 1'b1;
      adc_valid <= 1'b1;
      slow <= sl;
      @(posedge clk);
      rst_n <= 1'b1;
      n = 0;
      #1;
      while (adc_ready !== 1'b0 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("fifo full", adc_ready, 1'b0);
      fmt.got.delete();
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_USER_BYTE0 + 12'(k), 8'(8'h11 * (k + 1)), 2'b11);
      end
      wr(ADDR_TEST_MODE, ta, 2'b01);
      wr(ADDR_TEST_MODE, tb, 2'b10);
      adc_valid <= 1'b0;
      rchk("mode a", ADDR_TEST_MODE, 2'b01, ta);
      chk("active", test_act, 1'b1);
      @(posedge clk);
      hold <= 1'b0;
      n = 0;
      while (fmt.got.size() < 21 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk("drained", fmt.got.size() >= 21, 1'b1);
      for (int i = 0; i < 16 && i < fmt.got.size(); i++) begin
         s = fmt.got[i];
         chk("adc path", {s.a, s.b, s.test}, {adc_a, adc_b, 1'b0});
      end
      for (int i = 0; i < 5 && 16 + i < fmt.got.size(); i++) begin
         s = fmt.got[16 + i];
         // a mode write restarts the ramp at zero
         pa = (i == 0) ? 14'h3fff : fmt.got[15 + i].a;
         pb = (i == 0) ? 14'h3fff : fmt.got[15 + i].b;
         chk("word a", {s.raw_a, s.a}, expw(ta, i, pa));
         chk("word b", {s.raw_b, s.b}, expw(tb, i, pb));
         chk("test flag", s.test, 1'b1);
      end
   endtask
   // ********
   // main sequence
   // ********
   initial begin
      logic [11:0] da [4];
      da = '{ADDR_DDC0_TEST, ADDR_DDC1_TEST, ADDR_DDC2_TEST,
         ADDR_DDC3_TEST};
      for (int j = 0; j < 4; j++) begin
         usr[j] = 14'({8'(8'h11 * (2 * j + 2)), 8'(8'h11 * (2 * j + 1))} >> 2);
      end
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rchk("mode reset", ADDR_TEST_MODE, 2'b01, TM_RESET);
      chk("active reset", test_act, 1'b0);
      for (int k = 0; k < 4; k++) begin
         wr(da[k], 8'h05, 2'b01);
      end
      wr(ADDR_DDC0_TEST, 8'h04, 2'b01);
      rchk("ddc3 reg", ADDR_DDC3_TEST, 2'b01, 8'h05);
      chk("ddc off", ddc_en, 4'h0);
      @(posedge clk);
      ddc_mode <= 1'b1;
      @(posedge clk);
      #1;
      chk("ddc on", ddc_en, 4'he);
      wr(12'h123, 8'hff, 2'b01);
      rchk("unmapped", 12'h123, 2'b01, 8'h00);
      run(8'h04, 8'h07, 1'b0);
      run(8'h06, 8'h05, 1'b1);
      run(8'h01, 8'h02, 1'b0);
      run(8'h0f, 8'h03, 1'b1);
      run(8'h08, 8'h88, 1'b0);
      run(8'h88, 8'h08, 1'b1);
      run(8'h15, 8'h26, 1'b1);
      run(8'h07, 8'h0f, 1'b0);
      conclude();
   end
   // a hang is cut off well past the expected run length
   initial begin
      #(100 * 5000);
      fail_count++;
      conclude();
   end
endmodule // testbench
`default_nettype wire
